// ### cpudp_core.sv
// execution datapath: alu, flags, multiplier and data-space decoding
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - alu ops: register, immediate, single register
// RULE_02 - thirty-two byte registers, one-cycle access
// RULE_03 - six registers form three 16-bit pointers
// RULE_04 - arithmetic finishes in one cycle, written back
// RULE_05 - status flags updated after each operation
// RULE_06 - arithmetic, logic, bit classes; 8/16-bit math
// RULE_07 - multiplier: two bytes give 16-bit product
// RULE_08 - six signed/unsigned integer/fractional multiply kinds
// RULE_09 - multiply result available two cycles after issue
// RULE_10 - low 4KB is io; 0x00-0x3F direct
// RULE_11 - 0x0040-0x0FFF reachable only by load/store
// RULE_12 - 0x1000-0x1FFF reserved for nonvolatile window
// RULE_13 - sram begins at address 0x2000
// RULE_14 - no instruction fetch from sram
// RULE_15 - data and program spaces decoded separately
// RULE_16 - self program store only from boot section
// RULE_17 - fractional products shifted left one bit
// RULE_18 - io one cycle; sram write one, read two
module cpudp_core
    import cpudp_pkg::*;
#(
    parameter int          PROG_AW   = 16,
    parameter logic [15:0] BOOT_BASE = 16'hF000
) (
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST,
    // alu request from decode
    input  cpudp_alu_req_t            ALU_REQ,
    // multiply request
    input  cpudp_mul_req_t            MUL_REQ,
    output logic                      MUL_BUSY,
    output logic                      MUL_DONE,
    output logic [15:0]               MUL_PRODUCT,
    // data-space access
    input  cpudp_mem_req_t            MEM_REQ,
    input  wire logic [7:0]           MEM_RDATA,
    output logic                      MEM_READY,
    output logic                      MEM_FAULT,
    output logic                      SEL_IO,
    output logic                      SEL_NVM,
    output logic                      SEL_SRAM,
    output logic [15:0]               MEM_ADDR,
    output logic                      MEM_WE,
    output logic [7:0]                MEM_WDATA,
    // pointer readout
    input  wire logic [1:0]           PTR_SEL,
    output logic [15:0]               PTR_VALUE,
    // program space
    input  wire logic [PROG_AW-1:0]   FETCH_ADDR,
    input  wire logic                 FETCH_FROM_DATA,
    output logic                      FETCH_OK,
    input  wire logic                 SPM_REQ,
    input  wire logic [PROG_AW-1:0]   SPM_PC,
    output logic                      SPM_GRANT,
    // flags and result
    output logic [7:0]                FLAGS,
    output logic [7:0]                ALU_RESULT
);

    typedef struct packed {
        cpudp_state_t st;
        logic [7:0]   flags;
        logic [7:0]   result;
        logic [15:0]  prod;
        logic         mul_done;
        logic         spm_grant;
    } cpudp_core_state_t;

    cpudp_core_state_t s_q;
    cpudp_core_state_t s_d;

    logic [7:0]  rd_v;
    logic [7:0]  rr_v;
    logic        we0;
    logic [4:0]  wa0;
    logic [7:0]  wd0;
    logic        we1;
    logic [4:0]  wa1;
    logic [7:0]  wd1;
    logic [4:0]  ptr_idx;
    logic [7:0]  b_v;
    logic [8:0]  sum;
    logic [15:0] word_in;
    logic [16:0] word_out;
    logic [7:0]  res;
    logic [7:0]  fl;
    logic        wr_res;
    logic        is_word;
    cpudp_region_t region;
    logic        io_ok;

    // region decode, used for every data-space access
    function automatic cpudp_region_t cpudp_decode(input logic [15:0] a);
        if (a <= CPUDP_IO_LAST) begin
            return CPUDP_REG_IO;                          // see RULE_10
        end else if (a >= CPUDP_NVM_FIRST && a <= CPUDP_NVM_LAST) begin
            return CPUDP_REG_NVM;                         // see RULE_12
        end else begin
            return CPUDP_REG_SRAM;                        // see RULE_13
        end
    endfunction

    // signed/unsigned/fractional multiply of two bytes
    function automatic logic [15:0] cpudp_mul(input cpudp_mul_t k,
                                             input logic [7:0] a,
                                             input logic [7:0] b);
        logic signed [17:0] p;
        logic               sa;
        logic               sb;
        p  = '0;
        sa = (k == CPUDP_MUL_SS) || (k == CPUDP_MUL_SU) ||
             (k == CPUDP_MUL_FSS) || (k == CPUDP_MUL_FSU);
        sb = (k == CPUDP_MUL_SS) || (k == CPUDP_MUL_FSS);
        p  = $signed({sa & a[7], a}) * $signed({sb & b[7], b});  // see RULE_07, RULE_08
        if (k == CPUDP_MUL_FUU || k == CPUDP_MUL_FSS || k == CPUDP_MUL_FSU) begin
            return {p[14:0], 1'b0};                       // see RULE_17
        end
        return p[15:0];
    endfunction

    // three 16-bit pointers from the top six registers
    always_comb begin
        unique case (PTR_SEL)
            2'h0:    ptr_idx = CPUDP_PTR_X;               // see RULE_03
            2'h1:    ptr_idx = CPUDP_PTR_Y;
            default: ptr_idx = CPUDP_PTR_Z;
        endcase
    end

    cpudp_regfile #(
        .NREG (32)
    ) u_rf (
        .clk (CLK),
        .rst (RST),
        .ra  (ALU_REQ.valid ? ALU_REQ.rd : (MUL_REQ.valid ? MUL_REQ.rd : MEM_REQ.reg_idx)),
        .rb  (!ALU_REQ.valid ? MUL_REQ.rr : ALU_REQ.op inside {CPUDP_OP_ADIW, CPUDP_OP_SBIW}
              ? ALU_REQ.rd + 5'h01 : ALU_REQ.rr),  // word ops read rd+1
        .da  (rd_v),
        .db  (rr_v),
        .we0 (we0),
        .wa0 (wa0),
        .wd0 (wd0),
        .we1 (we1),
        .wa1 (wa1),
        .wd1 (wd1),
        .pa  (ptr_idx),
        .pd  (PTR_VALUE)
    );

    // alu: one-cycle compute, flags and write back
    always_comb begin
        b_v      = ALU_REQ.use_imm ? ALU_REQ.imm : rr_v;  // see RULE_01
        sum      = '0;
        word_in  = {rr_v, rd_v};
        word_out = '0;
        res      = rd_v;
        fl       = s_q.flags;
        wr_res   = 1'b1;
        is_word  = 1'b0;
        unique case (ALU_REQ.op)
            CPUDP_OP_ADD, CPUDP_OP_ADC: begin
                sum = {1'b0, rd_v} + {1'b0, b_v}
                      + {8'h00, ALU_REQ.op == CPUDP_OP_ADC && s_q.flags[CPUDP_FLAG_C]};
                res = sum[7:0];
                fl[CPUDP_FLAG_C] = sum[8];
                fl[CPUDP_FLAG_H] = (rd_v[3] & b_v[3]) | (b_v[3] & ~res[3]) | (~res[3] & rd_v[3]);
                fl[CPUDP_FLAG_V] = (rd_v[7] == b_v[7]) && (res[7] != rd_v[7]);
            end
            CPUDP_OP_SUB, CPUDP_OP_SBC, CPUDP_OP_CP, CPUDP_OP_NEG: begin
                if (ALU_REQ.op == CPUDP_OP_NEG) begin
                    sum = 9'h000 - {1'b0, rd_v};
                end else begin
                    sum = {1'b0, rd_v} - {1'b0, b_v}
                          - {8'h00, ALU_REQ.op == CPUDP_OP_SBC && s_q.flags[CPUDP_FLAG_C]};
                end
                res = sum[7:0];
                wr_res = (ALU_REQ.op != CPUDP_OP_CP);
                fl[CPUDP_FLAG_C] = sum[8];
                fl[CPUDP_FLAG_H] = (~rd_v[3] & b_v[3]) | (b_v[3] & res[3]) | (res[3] & ~rd_v[3]);
                fl[CPUDP_FLAG_V] = (rd_v[7] != b_v[7]) && (res[7] != rd_v[7]);
            end
            CPUDP_OP_AND, CPUDP_OP_OR, CPUDP_OP_XOR, CPUDP_OP_COM: begin
                unique case (ALU_REQ.op)
                    CPUDP_OP_AND: res = rd_v & b_v;       // see RULE_06
                    CPUDP_OP_OR:  res = rd_v | b_v;
                    CPUDP_OP_XOR: res = rd_v ^ b_v;
                    default: begin
                        res = ~rd_v;
                        fl[CPUDP_FLAG_C] = 1'b1;
                    end
                endcase
                fl[CPUDP_FLAG_V] = 1'b0;
            end
            CPUDP_OP_MOV: res = b_v;
            CPUDP_OP_INC, CPUDP_OP_DEC: begin
                res = (ALU_REQ.op == CPUDP_OP_INC) ? rd_v + 8'h01 : rd_v - 8'h01;
                fl[CPUDP_FLAG_V] = (ALU_REQ.op == CPUDP_OP_INC) ? (rd_v == 8'h7F)
                                                               : (rd_v == 8'h80);
            end
            CPUDP_OP_LSR, CPUDP_OP_ASR, CPUDP_OP_ROR: begin
                unique case (ALU_REQ.op)
                    CPUDP_OP_LSR: res = {1'b0, rd_v[7:1]};
                    CPUDP_OP_ASR: res = {rd_v[7], rd_v[7:1]};
                    default:      res = {s_q.flags[CPUDP_FLAG_C], rd_v[7:1]};
                endcase
                fl[CPUDP_FLAG_C] = rd_v[0];
                fl[CPUDP_FLAG_V] = res[7] ^ rd_v[0];
            end
            CPUDP_OP_SWAP: res = {rd_v[3:0], rd_v[7:4]};
            CPUDP_OP_BSET, CPUDP_OP_BCLR: begin
                wr_res = 1'b0;                            // bit functions touch flags only
                fl[ALU_REQ.bit_sel] = (ALU_REQ.op == CPUDP_OP_BSET);
            end
            CPUDP_OP_ADIW, CPUDP_OP_SBIW: begin
                is_word = 1'b1;                           // see RULE_06
                word_out = (ALU_REQ.op == CPUDP_OP_ADIW)
                         ? {1'b0, word_in} + {11'h000, ALU_REQ.imm[5:0]}
                         : {1'b0, word_in} - {11'h000, ALU_REQ.imm[5:0]};
                res = word_out[7:0];
                fl[CPUDP_FLAG_C] = word_out[16];
                fl[CPUDP_FLAG_V] = (ALU_REQ.op == CPUDP_OP_ADIW)
                                 ? (~word_in[15] & word_out[15]) : (word_in[15] & ~word_out[15]);
            end
            default: wr_res = 1'b0;
        endcase
        // shared zero/negative/sign flags; bit ops leave them be
        if (ALU_REQ.op != CPUDP_OP_BSET && ALU_REQ.op != CPUDP_OP_BCLR
            && ALU_REQ.op != CPUDP_OP_MOV && ALU_REQ.op != CPUDP_OP_SWAP) begin
            fl[CPUDP_FLAG_Z] = is_word ? (word_out[15:0] == 16'h0000) : (res == 8'h00);
            fl[CPUDP_FLAG_N] = is_word ? word_out[15] : res[7];     // see RULE_05
            fl[CPUDP_FLAG_S] = fl[CPUDP_FLAG_N] ^ fl[CPUDP_FLAG_V];
        end
    end

    // address decode of the current access
    always_comb begin
        region = cpudp_decode(MEM_REQ.addr);
        // direct io form reaches only the lowest 64 locations
        io_ok  = !MEM_REQ.direct_io || (MEM_REQ.addr <= CPUDP_IO_DIRECT_LAST); // see RULE_11
    end

    // write-port steering: alu has priority, then multiply done, then loads
    always_comb begin
        we0 = 1'b0;
        wa0 = ALU_REQ.rd;
        wd0 = res;
        we1 = 1'b0;
        wa1 = ALU_REQ.rd + 5'h01;
        wd1 = word_out[15:8];
        if (ALU_REQ.valid && wr_res) begin
            we0 = 1'b1;                                   // see RULE_04, RULE_02
            we1 = is_word;
        end else if (s_q.mul_done) begin
            we0 = 1'b1;
            wa0 = 5'h00;                                  // product lands in r1:r0
            wd0 = s_q.prod[7:0];
            we1 = 1'b1;
            wa1 = 5'h01;
            wd1 = s_q.prod[15:8];
        end else if (MEM_READY && !MEM_REQ.write && !MEM_FAULT) begin
            we0 = 1'b1;
            wa0 = MEM_REQ.reg_idx;
            wd0 = MEM_RDATA;
        end
    end

    // next state: multiply timing, sram read wait, flags and grants
    always_comb begin
        s_d          = s_q;
        s_d.mul_done = 1'b0;
        if (ALU_REQ.valid) begin
            s_d.flags  = fl;                              // see RULE_05
            s_d.result = res;
        end
        s_d.spm_grant = SPM_REQ && (SPM_PC >= BOOT_BASE[PROG_AW-1:0]);  // see RULE_16
        unique case (s_q.st)
            CPUDP_S_IDLE: begin
                if (MUL_REQ.valid) begin
                    s_d.prod = cpudp_mul(MUL_REQ.kind, rd_v, rr_v);
                    s_d.st   = CPUDP_S_MUL;               // see RULE_09
                end else if (MEM_REQ.valid && !MEM_REQ.write && region == CPUDP_REG_SRAM) begin
                    s_d.st  = CPUDP_S_RD;                 // see RULE_18
                end
            end
            CPUDP_S_MUL: begin
                s_d.mul_done = 1'b1;
                s_d.st       = CPUDP_S_IDLE;
            end
            CPUDP_S_RD: s_d.st = CPUDP_S_IDLE;
            default:    s_d.st = CPUDP_S_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q <= '{st: CPUDP_S_IDLE, flags: CPUDP_FLAGS_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // data-space port: io and writes answer at once, sram reads one cycle later
    assign SEL_IO    = MEM_REQ.valid && region == CPUDP_REG_IO;
    assign SEL_NVM   = MEM_REQ.valid && region == CPUDP_REG_NVM;
    assign SEL_SRAM  = MEM_REQ.valid && region == CPUDP_REG_SRAM;
    assign MEM_ADDR  = MEM_REQ.addr;
    assign MEM_WE    = MEM_REQ.valid && MEM_REQ.write && io_ok;
    assign MEM_WDATA = rd_v;
    assign MEM_FAULT = MEM_REQ.valid && !io_ok;
    assign MEM_READY = MEM_REQ.valid && (MEM_REQ.write || region != CPUDP_REG_SRAM
                       || s_q.st == CPUDP_S_RD || !io_ok);          // see RULE_18

    // fetch only from program space, never from sram
    assign FETCH_OK = !FETCH_FROM_DATA && (FETCH_ADDR <= {PROG_AW{1'b1}});  // see RULE_14, RULE_15

    assign MUL_BUSY    = (s_q.st == CPUDP_S_MUL);
    assign MUL_DONE    = s_q.mul_done;
    assign MUL_PRODUCT = s_q.prod;
    assign SPM_GRANT   = s_q.spm_grant;
    assign FLAGS       = s_q.flags;
    assign ALU_RESULT  = s_q.result;

endmodule

// ### cpudp_pkg.sv
// package of constants and carrier types for the cpu execution datapath
package cpudp_pkg;

    // data-space map
    localparam logic [15:0] CPUDP_IO_DIRECT_LAST = 16'h003F;
    localparam logic [15:0] CPUDP_IO_EXT_FIRST   = 16'h0040;
    localparam logic [15:0] CPUDP_IO_LAST        = 16'h0FFF;
    localparam logic [15:0] CPUDP_NVM_FIRST      = 16'h1000;
    localparam logic [15:0] CPUDP_NVM_LAST       = 16'h1FFF;
    localparam logic [15:0] CPUDP_SRAM_FIRST     = 16'h2000;

    // timing counts in cpu cycles
    localparam int CPUDP_MUL_CYCLES     = 2;
    localparam int CPUDP_SRAM_RD_CYCLES = 2;

    // pointer pair base indices (low byte register)
    localparam logic [4:0] CPUDP_PTR_X = 5'h1A;
    localparam logic [4:0] CPUDP_PTR_Y = 5'h1C;
    localparam logic [4:0] CPUDP_PTR_Z = 5'h1E;

    // status flag positions
    localparam int CPUDP_FLAG_C = 0;
    localparam int CPUDP_FLAG_Z = 1;
    localparam int CPUDP_FLAG_N = 2;
    localparam int CPUDP_FLAG_V = 3;
    localparam int CPUDP_FLAG_S = 4;
    localparam int CPUDP_FLAG_H = 5;
    localparam logic [7:0] CPUDP_FLAGS_RST = 8'h00;

    // alu operation codes
    typedef enum logic [4:0] {
        CPUDP_OP_ADD  = 5'h00, CPUDP_OP_ADC  = 5'h01, CPUDP_OP_SUB  = 5'h02,
        CPUDP_OP_SBC  = 5'h03, CPUDP_OP_AND  = 5'h04, CPUDP_OP_OR   = 5'h05,
        CPUDP_OP_XOR  = 5'h06, CPUDP_OP_MOV  = 5'h07, CPUDP_OP_COM  = 5'h08,
        CPUDP_OP_NEG  = 5'h09, CPUDP_OP_INC  = 5'h0A, CPUDP_OP_DEC  = 5'h0B,
        CPUDP_OP_LSR  = 5'h0C, CPUDP_OP_ASR  = 5'h0D, CPUDP_OP_ROR  = 5'h0E,
        CPUDP_OP_SWAP = 5'h0F, CPUDP_OP_BSET = 5'h10, CPUDP_OP_BCLR = 5'h11,
        CPUDP_OP_ADIW = 5'h12, CPUDP_OP_SBIW = 5'h13, CPUDP_OP_CP   = 5'h14
    } cpudp_op_t;

    // multiplier operand interpretations
    typedef enum logic [2:0] {
        CPUDP_MUL_UU  = 3'h0, CPUDP_MUL_SS  = 3'h1, CPUDP_MUL_SU  = 3'h2,
        CPUDP_MUL_FUU = 3'h3, CPUDP_MUL_FSS = 3'h4, CPUDP_MUL_FSU = 3'h5
    } cpudp_mul_t;

    // data-space region
    typedef enum logic [1:0] {
        CPUDP_REG_IO = 2'h0, CPUDP_REG_NVM = 2'h1, CPUDP_REG_SRAM = 2'h2
    } cpudp_region_t;

    // one alu request from decode
    typedef struct packed {
        logic       valid;
        cpudp_op_t  op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic       use_imm;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } cpudp_alu_req_t;

    // one multiply request
    typedef struct packed {
        logic       valid;
        cpudp_mul_t kind;
        logic [4:0] rd;
        logic [4:0] rr;
    } cpudp_mul_req_t;

    // one data-space access
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        direct_io;
        logic [15:0] addr;
        logic [4:0]  reg_idx;
    } cpudp_mem_req_t;

    // state machine of the multi-cycle unit
    typedef enum logic [2:0] {
        CPUDP_S_IDLE = 3'b001, CPUDP_S_MUL = 3'b010, CPUDP_S_RD = 3'b100
    } cpudp_state_t;

endpackage

// ### cpudp_regfile.sv
// thirty-two by eight register file with two read ports and registered pointer read
`timescale 1ns/1ps
module cpudp_regfile
    import cpudp_pkg::*;
#(
    parameter int NREG = 32
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // combinational operand reads
    input  wire logic [4:0]              ra,
    input  wire logic [4:0]              rb,
    output logic [7:0]                   da,
    output logic [7:0]                   db,
    // two write ports, port 1 writes rd+1 for word results
    input  wire logic                    we0,
    input  wire logic [4:0]              wa0,
    input  wire logic [7:0]              wd0,
    input  wire logic                    we1,
    input  wire logic [4:0]              wa1,
    input  wire logic [7:0]              wd1,
    // pointer view, registered
    input  wire logic [4:0]              pa,
    output logic [15:0]                  pd
);

    typedef struct packed {
        logic [NREG-1:0][7:0] r;
        logic [15:0]          pd;
    } cpudp_rf_state_t;

    cpudp_rf_state_t s_q;
    cpudp_rf_state_t s_d;

    // operands are read in the same cycle so one-cycle ops close in time
    assign da = s_q.r[ra];
    assign db = s_q.r[rb];
    assign pd = s_q.pd;

    // writes land at the edge; port 1 wins on a clash
    always_comb begin
        s_d = s_q;
        if (we0) begin
            s_d.r[wa0] = wd0;
        end
        if (we1) begin
            s_d.r[wa1] = wd1;
        end
        s_d.pd = {s_q.r[pa + 5'h01], s_q.r[pa]};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ### cpudp_core_asserts.sv
// port-level assertion checker for the cpu execution datapath
`timescale 1ns/1ps
module cpudp_core_asserts
    import cpudp_pkg::*;
#(
    parameter int          PROG_AW   = 16,
    parameter logic [15:0] BOOT_BASE = 16'hF000
) (
    // clock and reset
    input wire logic               CLK,
    input wire logic               RST,
    // requests
    input cpudp_alu_req_t          ALU_REQ,
    input cpudp_mul_req_t          MUL_REQ,
    input cpudp_mem_req_t          MEM_REQ,
    input wire logic               FETCH_FROM_DATA,
    input wire logic               SPM_REQ,
    input wire logic [PROG_AW-1:0] SPM_PC,
    // answers
    input wire logic               MUL_BUSY,
    input wire logic               MUL_DONE,
    input wire logic               MEM_READY,
    input wire logic               MEM_FAULT,
    input wire logic               MEM_WE,
    input wire logic               SEL_IO,
    input wire logic               SEL_NVM,
    input wire logic               SEL_SRAM,
    input wire logic               FETCH_OK,
    input wire logic               SPM_GRANT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // multiply issue and answer steps
    sequence mul_issue;
        MUL_REQ.valid && !MUL_BUSY && !MUL_DONE && !ALU_REQ.valid;
    endsequence
    sequence mul_answer;
        MUL_BUSY ##1 MUL_DONE;
    endsequence
    // a fresh sram read has one wait cycle
    sequence sram_rd;
        $rose(MEM_REQ.valid) && !MEM_REQ.write && SEL_SRAM;
    endsequence
    chk_mul_two_cyc: assert property (mul_issue |=> mul_answer)
        else $error("multiply answer not two cycles after issue");
    chk_done_pulse: assert property (MUL_DONE |=> !MUL_DONE)
        else $error("multiply done longer than one cycle");
    chk_sram_wait: assert property (sram_rd |-> !MEM_READY ##1 MEM_READY)
        else $error("sram read not ready in second cycle");
    chk_io_ready: assert property (MEM_REQ.valid && SEL_IO && !MEM_FAULT |-> MEM_READY)
        else $error("io access not ready in one cycle");
    chk_direct_io: assert property (MEM_REQ.valid && MEM_REQ.direct_io &&
        (MEM_REQ.addr > 16'h003F) |-> MEM_FAULT && !MEM_WE)
        else $error("direct io above 3F not refused");
    chk_io_region: assert property (MEM_REQ.valid && (MEM_REQ.addr <= 16'h0FFF) &&
        !MEM_FAULT |-> SEL_IO && !SEL_NVM && !SEL_SRAM)
        else $error("io region not selected");
    chk_nvm_region: assert property (MEM_REQ.valid &&
        (MEM_REQ.addr inside {[16'h1000:16'h1FFF]}) |-> SEL_NVM && !SEL_IO && !SEL_SRAM)
        else $error("nvm window not selected");
    chk_sram_start: assert property (MEM_REQ.valid && (MEM_REQ.addr >= 16'h2000)
        |-> SEL_SRAM && !SEL_NVM && !SEL_IO)
        else $error("sram not selected from 2000");
    chk_no_fetch: assert property (FETCH_FROM_DATA |-> !FETCH_OK)
        else $error("fetch from data space allowed");
    chk_spm_boot: assert property (SPM_REQ |=> SPM_GRANT == ($past(SPM_PC) >= BOOT_BASE))
        else $error("self program grant wrong for pc");
endmodule

bind cpudp_core cpudp_core_asserts #(.PROG_AW(PROG_AW), .BOOT_BASE(BOOT_BASE)) chk_u (
    .CLK(CLK), .RST(RST), .ALU_REQ(ALU_REQ), .MUL_REQ(MUL_REQ), .MEM_REQ(MEM_REQ),
    .FETCH_FROM_DATA(FETCH_FROM_DATA), .SPM_REQ(SPM_REQ), .SPM_PC(SPM_PC),
    .MUL_BUSY(MUL_BUSY), .MUL_DONE(MUL_DONE), .MEM_READY(MEM_READY), .MEM_FAULT(MEM_FAULT),
    .MEM_WE(MEM_WE), .SEL_IO(SEL_IO), .SEL_NVM(SEL_NVM), .SEL_SRAM(SEL_SRAM),
    .FETCH_OK(FETCH_OK), .SPM_GRANT(SPM_GRANT)
);

// ### cpudp_mem_model.sv
// far-side memory model feeding read data to the datapath
`timescale 1ns/1ps
module cpudp_mem_model (
    // clock
    input wire logic        clk,
    // access from the datapath
    input wire logic [15:0] addr,
    input wire logic        we,
    input wire logic        sel_sram,
    // read data back
    output logic [7:0]      rdata
);
    logic [7:0] last_q;
    // sram read gives an address pattern; otherwise toggles so stale data never matches
    assign rdata = (sel_sram && !we) ? (addr[7:0] ^ 8'hA5) : ~last_q;
    // history of the data lines
    initial last_q = 8'h00;
    always @(posedge clk) last_q <= rdata;
endmodule

// ### cpudp_core_tb.sv
// self-checking bench for the cpu execution datapath
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module cpudp_core_tb
    import cpudp_pkg::*;
();
    int             err_count;
    int             comparisons;
    logic           CLK, RST, ffd, spm_req, busy, done, rdy, flt, sio, snvm, ssram, we, fok, grant;
    logic [1:0]     ptr_sel;
    logic [15:0]    spm_pc, prod, maddr, ptr;
    logic [7:0]     rdata, wdata, flags, res;
    cpudp_alu_req_t alu_q;
    cpudp_mul_req_t mul_q;
    cpudp_mem_req_t mem_q;
    // device under test and its memory
    cpudp_core dut_u (.CLK(CLK), .RST(RST), .ALU_REQ(alu_q), .MUL_REQ(mul_q), .MUL_BUSY(busy),
        .MUL_DONE(done), .MUL_PRODUCT(prod), .MEM_REQ(mem_q), .MEM_RDATA(rdata),
        .MEM_READY(rdy), .MEM_FAULT(flt), .SEL_IO(sio), .SEL_NVM(snvm), .SEL_SRAM(ssram),
        .MEM_ADDR(maddr), .MEM_WE(we), .MEM_WDATA(wdata), .PTR_SEL(ptr_sel), .PTR_VALUE(ptr),
        .FETCH_ADDR(16'h0000), .FETCH_FROM_DATA(ffd), .FETCH_OK(fok), .SPM_REQ(spm_req),
        .SPM_PC(spm_pc), .SPM_GRANT(grant), .FLAGS(flags), .ALU_RESULT(res));
    cpudp_mem_model mem_u (.clk(CLK), .addr(maddr), .we(we), .sel_sram(ssram), .rdata(rdata));
    // 25 MHz clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // ops stay valid so calls run back to back; idle ends them
    task automatic alu(cpudp_op_t op, logic [4:0] rd, logic [4:0] rr, logic [7:0] k, logic ui);
        @(posedge CLK);
        alu_q <= '{1'b1, op, rd, rr, ui, k, 3'h0};
    endtask
    task automatic idle();
        @(posedge CLK);
        alu_q.valid <= 1'b0;
        @(negedge CLK);
    endtask
    task automatic load(logic [4:0] r, logic [7:0] v);
        alu(CPUDP_OP_AND, r, 5'h00, 8'h00, 1'b1);
        alu(CPUDP_OP_OR, r, 5'h00, v, 1'b1);
    endtask
    task automatic mem_on(logic w, logic d, logic [15:0] a, logic [4:0] r);
        @(posedge CLK);
        mem_q <= '{1'b1, w, d, a, r};
        @(negedge CLK);
    endtask
    task automatic mem_off();
        @(posedge CLK);
        mem_q.valid <= 1'b0;
    endtask
    // register seen as io store data
    task automatic peek(logic [4:0] r, logic [7:0] e);
        mem_on(1'b1, 1'b0, 16'h0000, r);
        `CHK(wdata, e)
        mem_off();
    endtask
    task automatic t_alu();
        load(5'h10, 8'h80);
        load(5'h11, 8'h80);
        alu(CPUDP_OP_ADD, 5'h10, 5'h11, 8'h00, 1'b0);
        idle();
        `CHK(res, 8'h00)
        `CHK(flags, 8'h1B)
        alu(CPUDP_OP_SUB, 5'h12, 5'h00, 8'h01, 1'b1);
        idle();
        `CHK(res, 8'hFF)
        `CHK(flags, 8'h35)
        alu(CPUDP_OP_COM, 5'h12, 5'h00, 8'h00, 1'b0);
        idle();
        `CHK(res, 8'h00)
        peek(5'h10, 8'h00);
        peek(5'h12, 8'h00);
        $display("alu test done");
    endtask
    task automatic t_ptr();
        @(posedge CLK);
        ptr_sel <= 2'h2;
        load(5'h1E, 8'hFF);
        load(5'h1F, 8'h12);
        idle();
        idle();
        `CHK(ptr, 16'h12FF)
        alu(CPUDP_OP_ADIW, 5'h1E, 5'h00, 8'h01, 1'b1);
        idle();
        idle();
        `CHK(ptr, 16'h1300)
        $display("pointer test done");
    endtask
    // operands C0 and 80 give a distinct product for every kind except FUU and FSU, which both give C000
    task automatic t_mul();
        logic [15:0] mexp [6] = '{16'h6000, 16'h2000, 16'hE000, 16'hC000, 16'h4000, 16'hC000};
        load(5'h14, 8'hC0);
        load(5'h15, 8'h80);
        idle();
        for (int k = 0; k < 6; k++) begin
            @(posedge CLK);
            mul_q <= '{1'b1, cpudp_mul_t'(k), 5'h14, 5'h15};
            @(posedge CLK);
            mul_q.valid <= 1'b0;
            @(negedge CLK);
            `CHK(busy, 1'b1)
            @(negedge CLK);
            `CHK(done, 1'b1)
            `CHK(prod, mexp[k])
            @(negedge CLK);
        end
        peek(5'h00, 8'h00);
        peek(5'h01, 8'hC0);
        $display("multiply test done");
    endtask
    task automatic t_mem();
        logic [15:0] da [7] = '{16'h003F, 16'h0040, 16'h0040, 16'h0FFF, 16'h1000, 16'h1FFF,
                                16'h2000};
        logic        dd [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        logic [2:0]  ds [7] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1};
        logic        f;
        for (int i = 0; i < 7; i++) begin
            mem_on(1'b1, dd[i], da[i], 5'h00);
            f = dd[i] && (da[i] > 16'h003F);
            `CHK(maddr, da[i])
            `CHK(flt, f)
            `CHK(we, !f)
            if (!f) begin
                `CHK({sio, snvm, ssram}, ds[i])
                `CHK(rdy, 1'b1)
            end
            mem_off();
        end
        mem_on(1'b0, 1'b0, 16'h2005, 5'h03);
        `CHK(rdy, 1'b0)
        @(negedge CLK);
        `CHK(rdy, 1'b1)
        mem_off();
        peek(5'h03, 8'hA0);
        $display("memory test done");
    endtask
    task automatic t_prog();
        @(posedge CLK);
        ffd <= 1'b1;
        spm_req <= 1'b1;
        spm_pc <= 16'hF000;
        @(negedge CLK);
        `CHK(fok, 1'b0)
        @(posedge CLK);
        ffd <= 1'b0;
        spm_pc <= 16'hEFFF;
        @(negedge CLK);
        `CHK(fok, 1'b1)
        `CHK(grant, 1'b1)
        @(posedge CLK);
        spm_req <= 1'b0;
        @(negedge CLK);
        `CHK(grant, 1'b0)
        $display("program space test done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {err_count, comparisons} = '0;
        {RST, ffd, spm_req, spm_pc, ptr_sel} = {1'b1, 20'h00000};
        {alu_q, mul_q, mem_q} = '0;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        t_alu();
        t_ptr();
        t_mul();
        t_mem();
        t_prog();
        give_verdict();
    end
    // watchdog, the tests need about 80 cycles
    initial begin
        repeat (3000) @(posedge CLK);
        err_count++;
        give_verdict();
    end
endmodule
